/* core/bwhp_regs.vh */
// Constants of the byte-wide host memory port: register offsets, fields, codes.
// Assumes inclusion by bare name from the design files under core/.
`ifndef BWHP_REGS_VH
`define BWHP_REGS_VH

// ****************************************************************
// Processor-side register offsets (byte addresses, one word each)
// ****************************************************************
`define BWHP_OFS_CTRL 4'h0
`define BWHP_OFS_STAT 4'h4
`define BWHP_OFS_ADDR 4'h8

// ****************************************************************
// Processor control register fields and reset values
// ****************************************************************
`define BWHP_CC_KEEP 0
`define BWHP_CC_HOST_INTERRUPT_N_SET 1
`define BWHP_CC_DINT_CLR 2
`define BWHP_KEEP_RST 1'h0

// ****************************************************************
// Processor status register fields
// ****************************************************************
`define BWHP_ST_DINT 0
`define BWHP_ST_HOST_INTERRUPT_N 1
`define BWHP_ST_BUSY 2

// ****************************************************************
// Host control word fields
// ****************************************************************
`define BWHP_HC_DINT 1
`define BWHP_HC_HOST_INTERRUPT_N 2
`define BWHP_HC_XSEL 4

// ****************************************************************
// Access target codes {sel_1, sel_0}
// ****************************************************************
`define BWHP_TGT_CTRL 2'h0
`define BWHP_TGT_MEMI 2'h1
`define BWHP_TGT_ADDR 2'h2
`define BWHP_TGT_MEM 2'h3

// ****************************************************************
// Memory operation states and synchroniser depth
// ****************************************************************
`define BWHP_S_IDLE 2'h0
`define BWHP_S_RD 2'h1
`define BWHP_S_WR 2'h2
`define BWHP_SYNC_STAGES 2

`endif

/* core/bwhp_host_port.v */
// Byte-wide host port: host strobed pins in, shared-memory requests out.
// Assumes clk keeps running from the reference clock in deep idle and that
// the memory answers a granted host access with a one-cycle mem_done.
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`include "bwhp_regs.vh"

module bwhp_host_port #(
  parameter AW = 23,
  parameter DW = 16,
  parameter NDMA = 6
) (
  input wire clk,
  input wire rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [7:0] host_data_lines_in,
  output wire [7:0] host_data_lines_out,
  output wire host_data_lines_oe,
  output wire host_bus_keeper_enable,
  input wire host_data_strobe_a_n,
  input wire host_data_strobe_b_n,
  input wire host_read_write_n,
  input wire host_addr_strobe_n,
  input wire byte_half_select,
  input wire access_target_sel_0,
  input wire access_target_sel_1,
  output wire host_ready,
  output wire host_interrupt_n,
  output wire [AW-1:0] mem_addr,
  output wire mem_wr,
  output wire [DW-1:0] mem_wdata,
  input wire [DW-1:0] mem_rdata,
  input wire mem_done,
  input wire cpu_mem_req,
  input wire [NDMA-1:0] dma_mem_req,
  output wire grant_host,
  output wire grant_cpu,
  output wire [NDMA-1:0] grant_dma,
  input wire idle_req,
  output wire clock_stop_ok
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // First byte on the pins is the high half of the word.
  function [7:0] half_of;
    input [15:0] w;
    input h;
    begin
      half_of = h ? w[7:0] : w[15:8];
    end
  endfunction

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  localparam PW = 15;
  localparam [3:0] P_A = 4'd14;
  localparam [3:0] P_B = 4'd13;
  localparam [3:0] P_RW = 4'd12;
  localparam [3:0] P_AS = 4'd11;
  localparam [3:0] P_H = 4'd10;
  localparam [3:0] P_S1 = 4'd9;
  localparam [3:0] P_S0 = 4'd8;

  wire [PW-1:0] pins;
  reg [PW-1:0] s1_q;
  reg [PW-1:0] s2_q;
  assign pins = {host_data_strobe_a_n, host_data_strobe_b_n, host_read_write_n,
                 host_addr_strobe_n, byte_half_select, access_target_sel_1,
                 access_target_sel_0, host_data_lines_in};

  always @(posedge clk) begin
    if (rst) begin
      s1_q <= {PW{1'b1}};
      s2_q <= {PW{1'b1}};
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  // Either strobe low counts, so a host may tie the unused one high.
  wire stb = ~s2_q[P_A] | ~s2_q[P_B];
  wire as_low = ~s2_q[P_AS];
  wire [7:0] din = s2_q[7:0];

  // ****************************************************************
  // Host access capture
  // ****************************************************************
  reg stb_q;
  reg as_q;
  reg as_seen_q;
  reg [3:0] lat_q;
  reg [3:0] cur_q;
  wire stb_rise = stb & ~stb_q;
  wire stb_fall = ~stb & stb_q;
  wire [3:0] live = {s2_q[P_RW], s2_q[P_H], s2_q[P_S1], s2_q[P_S0]};
  wire [3:0] eff = stb_q ? cur_q : (as_seen_q ? lat_q : live);
  wire e_rd = eff[3];
  wire e_half = eff[2];
  wire [1:0] e_tgt = eff[1:0];

  always @(posedge clk) begin
    if (rst) begin
      stb_q <= 1'b0;
      as_q <= 1'b0;
      as_seen_q <= 1'b0;
      lat_q <= 4'h0;
      cur_q <= 4'h0;
    end else begin
      stb_q <= stb;
      as_q <= as_low;
      // A multiplexed host latches control with the address strobe.
      if (as_low & ~as_q) begin
        lat_q <= live;
        as_seen_q <= 1'b1;
      end
      if (stb_rise)
        cur_q <= eff;
      if (stb_fall)
        as_seen_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Pointer, control and memory sequencing
  // ****************************************************************
  reg [AW-1:0] addr_q;
  reg xsel_q;
  reg [7:0] hold_q;
  reg [DW-1:0] rdbuf_q;
  reg [1:0] st_q;
  reg inc_q;
  reg mem_wr_q;
  reg [DW-1:0] wdata_q;
  reg host_interrupt_n_q;
  reg dint_q;
  reg keep_q;
  reg ready_q;
  reg [7:0] dout_q;
  reg doe_q;
  reg host_interrupt_n_n_q;
  reg grant_host_q;
  reg wait_q;

  wire [15:0] word = {hold_q, din};
  wire host_done = grant_host_q & mem_done;
  wire cpu_acc = (avs_read | avs_write) & ~wait_q;
  wire cpu_wr = cpu_acc & avs_write & avs_byteenable[0];
  wire cpu_ctrl_wr = cpu_wr & (avs_address == `BWHP_OFS_CTRL);
  wire host_ctrl_wr = stb_fall & ~cur_q[3] & cur_q[2] & (cur_q[1:0] == `BWHP_TGT_CTRL);
  wire [15:0] ctl_word = {11'h000, xsel_q, 1'b0, host_interrupt_n_q, dint_q, 1'b0};
  wire [15:0] ptr_word = xsel_q ? {9'h000, addr_q[AW-1:16]} : addr_q[15:0];
  // Ready drops only for a launched memory operation; a first byte or a
  // register read leaves it high.
  wire launch = stb_fall & cur_q[2] &
                (~cur_q[3] | (cur_q[1:0] == `BWHP_TGT_MEMI));

  always @(posedge clk) begin
    if (rst) begin
      addr_q <= {AW{1'b0}};
      xsel_q <= 1'b0;
      hold_q <= 8'h00;
      rdbuf_q <= {DW{1'b0}};
      st_q <= `BWHP_S_IDLE;
      inc_q <= 1'b0;
      mem_wr_q <= 1'b0;
      wdata_q <= {DW{1'b0}};
    end else begin
      case (st_q)
        `BWHP_S_RD: begin
          if (host_done) begin
            rdbuf_q <= mem_rdata;
            st_q <= `BWHP_S_IDLE;
          end
        end
        `BWHP_S_WR: begin
          if (host_done) begin
            // Refill the read buffer so it never holds stale data.
            if (inc_q)
              addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
            mem_wr_q <= 1'b0;
            st_q <= `BWHP_S_RD;
          end
        end
        `BWHP_S_IDLE: begin
          if (stb_fall & ~cur_q[3] & ~cur_q[2])
            hold_q <= din;
          if (stb_fall & ~cur_q[3] & cur_q[2]) begin
            case (cur_q[1:0])
              `BWHP_TGT_CTRL: begin
                xsel_q <= word[`BWHP_HC_XSEL];
                st_q <= `BWHP_S_RD;
              end
              `BWHP_TGT_ADDR: begin
                if (xsel_q)
                  addr_q[AW-1:16] <= word[AW-17:0];
                else
                  addr_q[15:0] <= word;
                st_q <= `BWHP_S_RD;
              end
              default: begin
                wdata_q <= word;
                mem_wr_q <= 1'b1;
                inc_q <= (cur_q[1:0] == `BWHP_TGT_MEMI);
                st_q <= `BWHP_S_WR;
              end
            endcase
          end
          if (stb_fall & cur_q[3] & cur_q[2] & (cur_q[1:0] == `BWHP_TGT_MEMI)) begin
            addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
            st_q <= `BWHP_S_RD;
          end
        end
        default: st_q <= `BWHP_S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Interrupt flags, keeper and pin drivers
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      host_interrupt_n_q <= 1'b0;
      dint_q <= 1'b0;
      keep_q <= `BWHP_KEEP_RST;
      ready_q <= 1'b1;
      dout_q <= 8'h00;
      doe_q <= 1'b0;
      host_interrupt_n_n_q <= 1'b1;
    end else begin
      // Setting wins over clearing for both flags.
      if (cpu_ctrl_wr & avs_writedata[`BWHP_CC_HOST_INTERRUPT_N_SET])
        host_interrupt_n_q <= 1'b1;
      else if (host_ctrl_wr & word[`BWHP_HC_HOST_INTERRUPT_N])
        host_interrupt_n_q <= 1'b0;
      if (host_ctrl_wr & word[`BWHP_HC_DINT])
        dint_q <= 1'b1;
      else if (cpu_ctrl_wr & avs_writedata[`BWHP_CC_DINT_CLR])
        dint_q <= 1'b0;
      if (cpu_ctrl_wr)
        keep_q <= avs_writedata[`BWHP_CC_KEEP];
      host_interrupt_n_n_q <= ~host_interrupt_n_q;
      ready_q <= (st_q == `BWHP_S_IDLE) & ~launch;
      doe_q <= stb & e_rd;
      if (stb & e_rd) begin
        case (e_tgt)
          `BWHP_TGT_CTRL: dout_q <= half_of(ctl_word, e_half);
          `BWHP_TGT_ADDR: dout_q <= half_of(ptr_word, e_half);
          default: dout_q <= half_of(rdbuf_q, e_half);
        endcase
      end
    end
  end

  // ****************************************************************
  // Memory arbiter
  // ****************************************************************
  // Address alone picks the location; program and data share one map.
  // The arbiter is reset only by rst, never by core reset or halt.
  wire host_req = (st_q != `BWHP_S_IDLE);
  reg [NDMA-1:0] grant_dma_q;
  reg grant_cpu_q;
  reg [NDMA-1:0] dma_first;
  integer i;

  always @* begin
    dma_first = {NDMA{1'b0}};
    for (i = NDMA - 1; i >= 0; i = i - 1) begin
      if (dma_mem_req[i])
        dma_first = {{(NDMA-1){1'b0}}, 1'b1} << i;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      grant_host_q <= 1'b0;
      grant_dma_q <= {NDMA{1'b0}};
      grant_cpu_q <= 1'b0;
    end else begin
      grant_host_q <= host_req & ~host_done;
      grant_dma_q <= host_req ? {NDMA{1'b0}} : dma_first;
      grant_cpu_q <= cpu_mem_req & ~host_req & ~|dma_mem_req;
    end
  end

  // ****************************************************************
  // Deep idle handshake
  // ****************************************************************
  // Clocks may stop once no strobe, host operation or DMA request is seen; a host launch at strobe end does not yet count.
  reg stop_ok_q;
  always @(posedge clk) begin
    if (rst)
      stop_ok_q <= 1'b0;
    else
      stop_ok_q <= idle_req & ~host_req & ~|dma_mem_req & ~stb;
  end

  // ****************************************************************
  // Processor register slave
  // ****************************************************************
  reg [31:0] rdata_q;
  always @(posedge clk) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (~wait_q) begin
      wait_q <= 1'b1;
    end else if (avs_read | avs_write) begin
      wait_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      if (avs_read) begin
        case (avs_address)
          `BWHP_OFS_CTRL: rdata_q <= {31'h0000_0000, keep_q};
          `BWHP_OFS_STAT: rdata_q <= {29'h0000_0000, host_req, host_interrupt_n_q, dint_q};
          `BWHP_OFS_ADDR: rdata_q <= {{(32-AW){1'b0}}, addr_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign host_data_lines_out = dout_q;
  assign host_data_lines_oe = doe_q;
  assign host_bus_keeper_enable = keep_q;
  assign host_ready = ready_q;
  assign host_interrupt_n = host_interrupt_n_n_q;
  assign mem_addr = addr_q;
  assign mem_wr = mem_wr_q;
  assign mem_wdata = wdata_q;
  assign grant_host = grant_host_q;
  assign grant_cpu = grant_cpu_q;
  assign grant_dma = grant_dma_q;
  assign clock_stop_ok = stop_ok_q;

endmodule // bwhp_host_port

/* testbench/bwhp_host_port_checker.sv */
// Assertions on the ports of the byte-wide host port.
// Assumes it is bound into bwhp_host_port.
module bwhp_host_port_checker #(
  parameter NDMA = 6
) (
  input wire clk,
  input wire rst,
  input wire [3:0] avs_address,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  input wire host_data_lines_oe,
  input wire host_bus_keeper_enable,
  input wire host_data_strobe_a_n,
  input wire host_data_strobe_b_n,
  input wire host_read_write_n,
  input wire host_ready,
  input wire host_interrupt_n,
  input wire mem_done,
  input wire mem_wr,
  input wire grant_host,
  input wire grant_cpu,
  input wire [NDMA-1:0] grant_dma,
  input wire idle_req,
  input wire clock_stop_ok
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_RDY_LOW: assert property ($rose(grant_host) |-> !host_ready)
    else $error("ready high at grant");
  AST_GRANT_NEXT: assert property ($fell(host_ready) |=> grant_host)
    else $error("no grant after launch");
  AST_RDY_BACK: assert property (grant_host && mem_done && !mem_wr |=> ##1 host_ready)
    else $error("ready late");
  AST_HOST_WINS: assert property (grant_host |-> grant_dma == '0 && !grant_cpu)
    else $error("host lost arbitration");
  AST_ONE_GRANT: assert property ($onehot0({grant_host, grant_cpu, grant_dma}))
    else $error("grants not one-hot");
  AST_STROBE: assert property ($fell(host_ready) |->
    $past(host_data_strobe_a_n) && $past(host_data_strobe_b_n))
    else $error("launch before strobe end");
  AST_OE_READ: assert property (host_data_lines_oe |-> host_read_write_n)
    else $error("data driven on host write");
  AST_INT_SET: assert property ($fell(host_interrupt_n) |-> $past(avs_write, 2) &&
    !$past(avs_waitrequest, 2) && $past(avs_address, 2) == 4'h0 &&
    $past(avs_writedata[1], 2))
    else $error("interrupt without request");
  AST_KEEP: assert property ($rose(host_bus_keeper_enable) |-> $past(avs_write) &&
    $past(avs_address) == 4'h0 && $past(avs_writedata[0]))
    else $error("keeper set without write");
  AST_IDLE: assert property ($rose(clock_stop_ok) |-> idle_req && grant_dma == '0)
    else $error("clock stop with DMA busy");
endmodule // bwhp_host_port_checker

bind bwhp_host_port bwhp_host_port_checker #(.NDMA(NDMA)) u_chk (.clk, .rst, .avs_address,
  .avs_write, .avs_writedata, .avs_waitrequest, .host_data_lines_oe, .host_bus_keeper_enable,
  .host_data_strobe_a_n, .host_data_strobe_b_n, .host_read_write_n, .host_ready,
  .host_interrupt_n, .mem_done, .mem_wr, .grant_host, .grant_cpu, .grant_dma, .idle_req,
  .clock_stop_ok);

/* testbench/bwhp_host_model.sv */
// Host processor model driving the byte-wide strobed pins.
// Assumes a free-running clk; the bench routes hd_host to the data pins.
module bwhp_host_model (
  input wire clk,
  input wire host_ready,
  input wire [7:0] host_data_lines_out,
  output logic host_data_strobe_a_n = 1'b1,
  output logic host_data_strobe_b_n = 1'b1,
  output logic host_read_write_n = 1'b1,
  output logic host_addr_strobe_n = 1'b1,
  output logic byte_half_select = 1'b0,
  output logic access_target_sel_0 = 1'b0,
  output logic access_target_sel_1 = 1'b0,
  output logic [7:0] hd_host = 8'h00,
  output logic [7:0] rd_byte = 8'h00,
  output logic rd_valid = 1'b0,
  output logic hang = 1'b0
);
  // ****
  // One byte access; s picks which strobe is used.
  // ****
  task acc(input logic r, input logic [1:0] tg, input logic h, input logic [7:0] d,
    input logic s);
    integer k;
    @(posedge clk);
    host_read_write_n <= r;
    {access_target_sel_1, access_target_sel_0} <= tg;
    byte_half_select <= h;
    hd_host <= d;
    host_addr_strobe_n <= ~s;
    @(posedge clk);
    host_addr_strobe_n <= 1'b1;
    if (s) host_data_strobe_b_n <= 1'b0;
    else host_data_strobe_a_n <= 1'b0;
    repeat (6) @(posedge clk);
    rd_byte <= host_data_lines_out;
    rd_valid <= r;
    @(posedge clk);
    host_data_strobe_a_n <= 1'b1;
    host_data_strobe_b_n <= 1'b1;
    rd_valid <= 1'b0;
    repeat (5) @(posedge clk);
    for (k = 0; k < 60 && host_ready !== 1'b1; k++) @(posedge clk);
    hang <= (k == 60);
    hd_host <= ~hd_host;
  endtask
endmodule // bwhp_host_model

/* testbench/test_byte_wide_host_memory_port.sv */
// Self-checking bench of the byte-wide host port.
// Assumes the port, its checker and the host model are compiled first.
`include "bwhp_regs.vh"
module test_byte_wide_host_memory_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [15:0] mem_rdata = 16'h0000;
  logic mem_done = 1'b0;
  logic cpu_mem_req = 1'b0;
  logic idle_req = 1'b0;
  logic traf = 1'b1;
  logic [5:0] dma_mem_req = 6'h00;
  logic [1:0] dly = 2'h0;
  logic [15:0] mem [int];
  logic [31:0] q [$];
  logic [15:0] w1, w2, w3, w4;
  integer seed = 32'h43b1;
  integer num_errors = 0;
  integer n_tests = 0;
  integer i;
  wire [31:0] avs_readdata;
  wire [22:0] mem_addr;
  wire [15:0] mem_wdata;
  wire [7:0] host_data_lines_in, host_data_lines_out, hd_host, rd_byte;
  wire [5:0] grant_dma;
  wire avs_waitrequest, host_data_lines_oe, host_bus_keeper_enable, host_ready;
  wire host_data_strobe_a_n, host_data_strobe_b_n, host_read_write_n, host_addr_strobe_n;
  wire byte_half_select, access_target_sel_0, access_target_sel_1, host_interrupt_n;
  wire mem_wr, grant_host, grant_cpu, clock_stop_ok, rd_valid, hang;

  always #2.5 clk = ~clk;
  assign host_data_lines_in = host_data_lines_oe ? host_data_lines_out : hd_host;

  bwhp_host_port uut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .host_data_lines_in,
    .host_data_lines_out, .host_data_lines_oe, .host_bus_keeper_enable, .host_data_strobe_a_n,
    .host_data_strobe_b_n, .host_read_write_n, .host_addr_strobe_n, .byte_half_select,
    .access_target_sel_0, .access_target_sel_1, .host_ready, .host_interrupt_n, .mem_addr,
    .mem_wr, .mem_wdata, .mem_rdata, .mem_done, .cpu_mem_req, .dma_mem_req, .grant_host,
    .grant_cpu, .grant_dma, .idle_req, .clock_stop_ok);
  bwhp_host_model hm (.clk, .host_ready, .host_data_lines_out, .host_data_strobe_a_n,
    .host_data_strobe_b_n, .host_read_write_n, .host_addr_strobe_n, .byte_half_select,
    .access_target_sel_0, .access_target_sel_1, .hd_host, .rd_byte, .rd_valid, .hang);

  // ****
  // Memory with a random answer delay, and competing requesters.
  // ****
  always @(posedge clk) begin
    mem_done <= 1'b0;
    if (grant_host === 1'b1 && !mem_done) begin
      if (dly == 2'h0) begin
        mem_done <= 1'b1;
        mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_rdata;
        if (mem_wr === 1'b1) mem[mem_addr] = mem_wdata;
        dly <= 2'($random(seed));
      end else dly <= dly - 2'h1;
    end
    cpu_mem_req <= traf & 1'($random(seed));
    dma_mem_req <= traf ? 6'($random(seed)) : 6'h00;
  end

  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, q.pop_front());
    if (rd_valid) check({24'h0, rd_byte}, q.pop_front());
    if (hang) begin
      num_errors++;
      final_report;
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task av(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    integer k;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    for (k = 0; k < 50 && avs_waitrequest !== 1'b0; k++) @(posedge clk);
    if (k < 50) begin
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end else begin
      num_errors++;
      final_report;
    end
  endtask

  task rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    av(1'b0, a, 32'h0000_0000, 4'hf);
  endtask

  task hw(input logic [1:0] tg, input logic [15:0] w);
    hm.acc(1'b0, tg, 1'b0, w[15:8], 1'($random(seed)));
    hm.acc(1'b0, tg, 1'b1, w[7:0], 1'($random(seed)));
  endtask

  task hr(input logic [1:0] tg, input logic [15:0] w);
    q.push_back({24'h0, w[15:8]});
    hm.acc(1'b1, tg, 1'b0, 8'h00, 1'($random(seed)));
    q.push_back({24'h0, w[7:0]});
    hm.acc(1'b1, tg, 1'b1, 8'h00, 1'($random(seed)));
  endtask

  initial begin
    w1 = 16'($random(seed));
    w2 = 16'($random(seed));
    w3 = 16'($random(seed));
    w4 = 16'($random(seed));
    mem[23'h5a_1235] = w3;
    mem[23'h5a_1236] = w4;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(`BWHP_OFS_CTRL, 32'h0000_0000);
    rd(4'hc, 32'h0000_0000);
    hw(`BWHP_TGT_CTRL, 16'h0010);
    hw(`BWHP_TGT_ADDR, 16'h005a);
    hw(`BWHP_TGT_CTRL, 16'h0000);
    hw(`BWHP_TGT_ADDR, 16'h1234);
    rd(`BWHP_OFS_ADDR, 32'h005a_1234);
    hw(`BWHP_TGT_MEM, w1);
    hr(`BWHP_TGT_MEM, w1);
    hw(`BWHP_TGT_MEMI, w2);
    check({16'h0000, mem[23'h5a_1234]}, {16'h0000, w2});
    hr(`BWHP_TGT_MEMI, w3);
    rd(`BWHP_OFS_ADDR, 32'h005a_1236);
    av(1'b1, `BWHP_OFS_CTRL, 32'h0000_0012, 4'hf);
    hr(`BWHP_TGT_CTRL, 16'h0004);
    check({31'h0, host_interrupt_n}, 32'h0000_0000);
    hw(`BWHP_TGT_CTRL, 16'h0004);
    check({31'h0, host_interrupt_n}, 32'h0000_0001);
    hw(`BWHP_TGT_CTRL, 16'h0002);
    rd(`BWHP_OFS_STAT, 32'h0000_0001);
    av(1'b1, `BWHP_OFS_CTRL, 32'h0000_0004, 4'hf);
    av(1'b1, `BWHP_OFS_CTRL, 32'h0000_0001, 4'h0);
    av(1'b1, 4'hc, 32'h0000_0001, 4'hf);
    rd(`BWHP_OFS_STAT, 32'h0000_0000);
    av(1'b1, `BWHP_OFS_CTRL, 32'h0000_0001, 4'hf);
    rd(`BWHP_OFS_CTRL, 32'h0000_0001);
    check({31'h0, host_bus_keeper_enable}, 32'h0000_0001);
    traf <= 1'b0;
    idle_req <= 1'b1;
    for (i = 0; i < 100 && clock_stop_ok !== 1'b1; i++) @(posedge clk);
    check({31'h0, clock_stop_ok}, 32'h0000_0001);
    hr(`BWHP_TGT_MEM, w4);
    hw(`BWHP_TGT_MEM, w1);
    check({16'h0000, mem[23'h5a_1236]}, {16'h0000, w1});
    final_report;
  end
endmodule // test_byte_wide_host_memory_port
